// ===== core/bsu_params.svh
// Purpose: Offsets, field positions, codes and timing of the byte unit
// Assumes: Included by bare name; definitions only
// Notes:   Status codes sit in bits 7:3 of the status register
`ifndef BSU_PARAMS_SVH
`define BSU_PARAMS_SVH

// ****************************************************
// Register byte addresses
// ****************************************************
`define BSU_OFF_CTRL      4'h0
`define BSU_OFF_STATUS    4'h4
`define BSU_OFF_DATA      4'h8
`define BSU_OFF_CPUFLAGS  4'hc

// ****************************************************
// Control fields
// ****************************************************
`define BSU_CTRL_DONE     7
`define BSU_CTRL_START    5
`define BSU_CTRL_STOP     4
`define BSU_CTRL_EN       2
`define BSU_CTRL_IE       0
`define BSU_CPU_GIE       7

// ****************************************************
// Status codes, five bits, shown in status bits 7:3
// ****************************************************
`define BSU_ST_START      5'h01
`define BSU_ST_RSTART     5'h02
`define BSU_ST_SLA_ACK    5'h03
`define BSU_ST_SLA_NACK   5'h04
`define BSU_ST_DAT_ACK    5'h05
`define BSU_ST_DAT_NACK   5'h06
`define BSU_ST_IDLE       5'h1f

// ****************************************************
// Bus answers and timing
// ****************************************************
`define BSU_RESP_OKAY     2'h0
`define BSU_RESP_SLVERR   2'h2
`define BSU_CLK_NS        20
`define BSU_QTR_NS        40
`define BSU_QTR_CYC       (((`BSU_QTR_NS + `BSU_CLK_NS - 1) / `BSU_CLK_NS))
`define BSU_ACK_BIT       4'h8

`endif

// ===== core/bsu_pkg.sv
// Purpose: Types shared by the byte serial unit
// Assumes: Nothing beyond the synthesis tool
// Notes:   Constants live in bsu_params.svh
package bsu_pkg;

  typedef enum logic [2:0] {
    ENG_IDLE,
    ENG_WAIT,
    ENG_START,
    ENG_BIT,
    ENG_STOP
  } bsu_eng_t;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } bsu_sync_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } bsu_div_t;

  typedef struct packed {
    logic       aw_ok;
    logic [3:0] aw_addr;
    logic       awrdy;
    logic       w_ok;
    logic [7:0] wdata;
    logic       wbe;
    logic       wrdy;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arrdy;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic       done;
    logic       sta;
    logic       sto;
    logic       en;
    logic       ie;
    logic       gie;
    logic [1:0] presc;
    logic [4:0] code;
    logic [7:0] data;
    bsu_eng_t   st;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic       in_bus;
    logic       addr_ph;
    logic       scl_oe;
    logic       sda_oe;
    logic       irq;
  } bsu_state_t;

endpackage : bsu_pkg

// ===== core/bsu_pin_if.sv
// Purpose: Carries raw and synchronised line levels between modules
// Assumes: Index 0 is the clock line, index 1 the data line
// Notes:   Raw levels come from another domain
`timescale 1ns/1ps
`default_nettype none
interface bsu_pin_if;
  logic [1:0] raw;
  logic [1:0] synced;
  modport sync (input raw, output synced);
  modport core (output raw, input synced);
endinterface : bsu_pin_if
`default_nettype wire

// ===== core/bsu_sync.sv
// Purpose: Two-stage synchroniser for the two line levels
// Assumes: One clock, asynchronous active-low reset
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module bsu_sync
  import bsu_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Lines
  bsu_pin_if.sync   pins
);
  bsu_sync_t s;
  bsu_sync_t n;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      assign n.meta[i] = pins.raw[i];
      assign n.sync[i] = s.meta[i];
    end
  endgenerate

  assign pins.synced = s.sync;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) s <= '{meta: 2'h3, sync: 2'h3};
    else        s <= n;
  end
endmodule : bsu_sync
`default_nettype wire

// ===== core/bsu_div.sv
// Purpose: Quarter-bit tick divider for the line engine
// Assumes: Limit stays at or above one
// Notes:   Tick is a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module bsu_div
  import bsu_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Rate
  input  wire logic [7:0] limit,
  output logic            tick
);
  bsu_div_t s;
  bsu_div_t n;

  always_comb begin
    n      = s;
    n.tick = 1'b0;
    if (s.cnt >= limit - 8'h01) begin
      n.cnt  = 8'h00;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 8'h01;
    end
  end

  assign tick = s.tick;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) s <= '{cnt: 8'h00, tick: 1'b0};
    else        s <= n;
  end
endmodule : bsu_div
`default_nettype wire

// ===== core/bsu_top.sv
// Purpose: Byte serial unit, master transmit path with software handshake
// Assumes: AXI4-Lite slave, open-drain lines, one clock mclk
// Notes:   Line clock is sampled, never used as a clock
`timescale 1ns/1ps
`default_nettype none
`include "bsu_params.svh"
module bsu_top
  import bsu_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Serial clock line
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  // Serial data line
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Interrupt request
  output logic             irq
);

  // ****************************************************
  // Synchronisers and divider
  // ****************************************************
  bsu_pin_if pins ();
  assign pins.raw = {sda_i, scl_i};

  bsu_sync u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pins  (pins)
  );

  logic       tick;
  logic [7:0] limit;
  logic       scl_s;
  logic       sda_s;
  logic [1:0] s_presc_w;

  assign scl_s = pins.synced[0];
  assign sda_s = pins.synced[1];

  // Prescaler stretches the quarter-bit time by powers of two
  assign limit = 8'(`BSU_QTR_CYC) << s_presc_w;

  bsu_div u_div (
    .mclk  (mclk),
    .rst_n (rst_n),
    .limit (limit),
    .tick  (tick)
  );

  // ****************************************************
  // State
  // ****************************************************
  bsu_state_t s;
  bsu_state_t n;
  assign s_presc_w = s.presc;

  localparam bsu_state_t RST = '{
    aw_ok: 1'b0, aw_addr: 4'h0, awrdy: 1'b0,
    w_ok: 1'b0, wdata: 8'h00, wbe: 1'b0, wrdy: 1'b0,
    bvalid: 1'b0, bresp: 2'h0, arrdy: 1'b0,
    rvalid: 1'b0, rdata: 8'h00, rresp: 2'h0,
    done: 1'b0, sta: 1'b0, sto: 1'b0, en: 1'b0, ie: 1'b0,
    gie: 1'b0, presc: 2'h0, code: `BSU_ST_IDLE, data: 8'h00,
    st: ENG_IDLE, ph: 2'h0, bitn: 4'h0, sh: 8'h00,
    in_bus: 1'b0, addr_ph: 1'b0,
    scl_oe: 1'b0, sda_oe: 1'b0, irq: 1'b0
  };

  logic wr_fire;
  logic wr_ok;
  logic go;

  always_comb begin
    n       = s;
    wr_fire = 1'b0;
    wr_ok   = 1'b0;
    go      = 1'b0;

    // ****************************************************
    // Line engine, advances on quarter-bit ticks
    // ****************************************************
    case (s.st)
      ENG_IDLE: begin
        n.scl_oe = 1'b0;
      end
      ENG_WAIT: begin
        n.scl_oe = 1'b1;
      end
      ENG_START: begin
        if (tick) begin
          case (s.ph)
            2'h0: begin
              n.sda_oe = 1'b0;
              n.scl_oe = 1'b0;
              n.ph     = 2'h1;
            end
            2'h1: begin
              // Slave may still stretch the clock low
              if (scl_s) n.ph = 2'h2;
            end
            2'h2: begin
              n.sda_oe = 1'b1;
              n.ph     = 2'h3;
            end
            default: begin
              n.scl_oe  = 1'b1;
              n.done    = 1'b1;
              n.code    = s.in_bus ? `BSU_ST_RSTART
                                   : `BSU_ST_START;
              n.in_bus  = 1'b1;
              n.addr_ph = 1'b1;
              n.st      = ENG_WAIT;
            end
          endcase
        end
      end
      ENG_BIT: begin
        if (tick) begin
          case (s.ph)
            2'h0: begin
              // Ninth clock releases data for the acknowledge
              n.sda_oe = (s.bitn < `BSU_ACK_BIT) ? ~s.sh[7]
                                                 : 1'b0;
              n.ph     = 2'h1;
            end
            2'h1: begin
              n.scl_oe = 1'b0;
              n.ph     = 2'h2;
            end
            2'h2: begin
              if (scl_s) n.ph = 2'h3;
            end
            default: begin
              n.scl_oe = 1'b1;
              n.ph     = 2'h0;
              if (s.bitn == `BSU_ACK_BIT) begin
                n.done    = 1'b1;
                n.addr_ph = 1'b0;
                n.st      = ENG_WAIT;
                if (s.addr_ph) begin
                  n.code = sda_s ? `BSU_ST_SLA_NACK
                                 : `BSU_ST_SLA_ACK;
                end else begin
                  n.code = sda_s ? `BSU_ST_DAT_NACK
                                 : `BSU_ST_DAT_ACK;
                end
              end else begin
                n.sh   = {s.sh[6:0], 1'b0};
                n.bitn = s.bitn + 4'h1;
              end
            end
          endcase
        end
      end
      ENG_STOP: begin
        if (tick) begin
          case (s.ph)
            2'h0: begin
              n.sda_oe = 1'b1;
              n.ph     = 2'h1;
            end
            2'h1: begin
              n.scl_oe = 1'b0;
              n.ph     = 2'h2;
            end
            2'h2: begin
              if (scl_s) n.ph = 2'h3;
            end
            default: begin
              // Flag stays clear so software is not stalled
              n.sda_oe = 1'b0;
              n.in_bus = 1'b0;
              n.code   = `BSU_ST_IDLE;
              n.st     = ENG_IDLE;
            end
          endcase
        end
      end
      default: begin
        n.st = ENG_IDLE;
      end
    endcase

    // ****************************************************
    // AXI4-Lite write channel
    // ****************************************************
    if (s_axi_awvalid && s.awrdy) begin
      n.aw_ok   = 1'b1;
      n.aw_addr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s.wrdy) begin
      n.w_ok  = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wbe   = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;

    if (s.aw_ok && s.w_ok && !s.bvalid) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      wr_ok    = (s.aw_addr == `BSU_OFF_CTRL)   ||
                 (s.aw_addr == `BSU_OFF_STATUS) ||
                 (s.aw_addr == `BSU_OFF_DATA)   ||
                 (s.aw_addr == `BSU_OFF_CPUFLAGS);
      n.bresp  = wr_ok ? `BSU_RESP_OKAY : `BSU_RESP_SLVERR;
      wr_fire  = wr_ok && s.wbe;
    end

    if (wr_fire) begin
      case (s.aw_addr)
        `BSU_OFF_CTRL: begin
          n.ie  = s.wdata[`BSU_CTRL_IE];
          n.en  = s.wdata[`BSU_CTRL_EN];
          n.sta = s.wdata[`BSU_CTRL_START];
          n.sto = s.wdata[`BSU_CTRL_STOP];
          // Clear acts only while idle or waiting, so an engine set is never lost
          if (s.wdata[`BSU_CTRL_DONE] &&
              ((s.st == ENG_IDLE) || (s.st == ENG_WAIT)))
            n.done = 1'b0;
          // Held flag blocks launch unless this write clears it
          go = s.wdata[`BSU_CTRL_EN] &&
               (!s.done || s.wdata[`BSU_CTRL_DONE]) &&
               ((s.st == ENG_IDLE) || (s.st == ENG_WAIT));
        end
        `BSU_OFF_STATUS: begin
          n.presc = s.wdata[1:0];
        end
        `BSU_OFF_DATA: begin
          // Loads during a shift would corrupt the packet
          if ((s.st == ENG_IDLE) || (s.st == ENG_WAIT))
            n.data = s.wdata;
        end
        default: begin
          n.gie = s.wdata[`BSU_CPU_GIE];
        end
      endcase
    end

    // ****************************************************
    // Launch of the operation the control write selects
    // ****************************************************
    if (go) begin
      n.ph   = 2'h0;
      n.bitn = 4'h0;
      n.sta  = 1'b0;
      n.sto  = 1'b0;
      if (s.wdata[`BSU_CTRL_START]) begin
        n.st = ENG_START;
      end else if (s.wdata[`BSU_CTRL_STOP] && s.in_bus) begin
        n.st = ENG_STOP;
      end else if (s.in_bus) begin
        n.st = ENG_BIT;
        n.sh = s.data;
      end else begin
        n.st = ENG_IDLE;
      end
    end

    // ****************************************************
    // AXI4-Lite read channel
    // ****************************************************
    if (s.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s_axi_arvalid && s.arrdy) begin
      n.rvalid = 1'b1;
      n.rresp  = `BSU_RESP_OKAY;
      case (s_axi_araddr[3:0])
        `BSU_OFF_CTRL: begin
          n.rdata = {s.done, 1'b0, s.sta, s.sto,
                     1'b0, s.en, 1'b0, s.ie};
        end
        `BSU_OFF_STATUS: begin
          n.rdata = {s.code, 1'b0, s.presc};
        end
        `BSU_OFF_DATA: begin
          n.rdata = s.data;
        end
        `BSU_OFF_CPUFLAGS: begin
          n.rdata = {s.gie, 7'h00};
        end
        default: begin
          n.rdata = 8'h00;
          n.rresp = `BSU_RESP_SLVERR;
        end
      endcase
    end

    // ****************************************************
    // Ready flags and interrupt level
    // ****************************************************
    // Write readies stay low until the write answer is taken, read ready until the read answer
    n.awrdy = !n.aw_ok && !n.bvalid;
    n.wrdy  = !n.w_ok && !n.bvalid;
    n.arrdy = !n.rvalid;
    n.irq   = n.done && n.ie && n.gie;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) s <= RST;
    else        s <= n;
  end

  // ****************************************************
  // Outputs, all from flip-flops except scl_o, sda_o and s_axi_rdata bits 31:8, tied low
  // ****************************************************
  assign s_axi_awready = s.awrdy;
  assign s_axi_wready  = s.wrdy;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arrdy;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = {24'h000000, s.rdata};
  assign s_axi_rresp   = s.rresp;
  assign scl_o         = 1'b0;
  assign sda_o         = 1'b0;
  assign scl_oe        = s.scl_oe;
  assign sda_oe        = s.sda_oe;
  assign irq           = s.irq;

endmodule : bsu_top
`default_nettype wire

// ===== tb/bsu_top_checker.sv
// Purpose: Port-level checks of the byte serial unit
// Assumes: Bound to bsu_top; one clock domain
// Notes:   Done flag is visible at the ports through irq while ie and gie are set, and through control register read data
`timescale 1ns/1ps
`default_nettype none
module bsu_top_checker (
  // Clock and reset
  input wire logic        mclk, rst_n,
  // Register bus
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid,
  input wire logic        s_axi_arready, s_axi_rvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  // Lines and request
  input wire logic        scl_oe, sda_oe, irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****************************************************
  // Handshake with software
  // ****************************************************
  scl_hold_a: assert property (irq |-> scl_oe)
    else $error("clock line released while done flag raised");
  lines_frozen_a: assert property (
    irq && $past(irq) |-> $stable({scl_oe, sda_oe}))
    else $error("line activity while done flag raised");
  irq_level_a: assert property (irq && s_axi_awready |=> irq)
    else $error("request dropped with no register write");
  irq_drop_a: assert property (
    $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("request fell outside a write");
  // ****************************************************
  // Register bus
  // ****************************************************
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  aw_refuse_a: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("second address taken during a write");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rdata_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  irq_seen_c: cover property ($rose(irq));
  stop_seen_c: cover property (!scl_oe && $fell(sda_oe));
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : bsu_top_checker
bind bsu_top bsu_top_checker i_chk (.mclk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bresp,
  .s_axi_rdata, .scl_oe, .sda_oe, .irq);
`default_nettype wire

// ===== tb/bsu_slave_model.sv
// Purpose: Behavioural receiving slave on the two lines
// Assumes: Lines pulled up; pull outputs high mean drive low
// Notes:   Optional clock stretch after every falling clock
`timescale 1ns/1ps
`default_nettype none
module bsu_slave_model (
  // Line levels
  input  wire logic scl,
  input  wire logic sda,
  // Behaviour select
  input  wire logic ack_en,
  input  wire logic slow,
  // Line drives
  output logic       sda_pull,
  output logic       scl_pull,
  // Last byte received
  output logic [7:0] last_byte
);
  logic [3:0] nbits;
  logic [7:0] sh;
  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    nbits = 4'h0;
    sh = 8'h00;
    last_byte = 8'h00;
  end
  // Start and repeated start restart the packet
  always @(negedge sda) if (scl) nbits = 4'h0;
  always @(posedge scl) begin
    if (nbits < 4'h8) sh = {sh[6:0], sda};
    nbits = nbits + 4'h1;
    if (nbits == 4'h8) last_byte = sh;
  end
  always @(negedge scl) begin
    sda_pull = (nbits == 4'h8) && ack_en;
    if (nbits == 4'h9) nbits = 4'h0;
    if (slow) begin
      scl_pull = 1'b1;
      #300;
      scl_pull = 1'b0;
    end
  end
endmodule : bsu_slave_model
`default_nettype wire

// ===== tb/test_two_wire_sw_handshake.sv
// Purpose: Software handshake bench for the byte serial unit
// Assumes: Register bus master tasks; pulled-up lines
// Notes:   Done flag is polled through the control register
`timescale 1ns/1ps
`default_nettype none
`include "bsu_params.svh"
module test_two_wire_sw_handshake;
  logic        mclk = 1'b0, rst_n = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic        awr, wr, bv, arr, rv, scl_oe, sda_oe, irq;
  logic        scl_pull, sda_pull, ack_en = 1'b0, slow = 1'b0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rd;
  logic [1:0]  bresp, rresp;
  logic [7:0]  last_byte, v;
  wire logic   scl_ln, sda_ln;
  int          err_count = 0, samples_checked = 0, n;
  // Step table: control, data, slave ack, stretch, status code
  localparam logic [7:0] step_ctrl[6] =
    '{8'ha5, 8'h85, 8'h85, 8'h84, 8'ha4, 8'h84};
  localparam logic [7:0] step_data[6] =
    '{8'ha4, 8'ha4, 8'h3c, 8'hc3, 8'hc3, 8'ha5};
  localparam logic [5:0] ack_mask = 6'b000110;
  localparam logic [5:0] slow_mask = 6'b000100;
  localparam logic [4:0] step_code[6] = '{`BSU_ST_START, `BSU_ST_SLA_ACK,
    `BSU_ST_DAT_ACK, `BSU_ST_DAT_NACK, `BSU_ST_RSTART, `BSU_ST_SLA_NACK};
  // Wired-AND of open-drain drivers
  assign scl_ln = ~(scl_oe | scl_pull);
  assign sda_ln = ~(sda_oe | sda_pull);
  always #10 mclk = ~mclk;
  bsu_top i_dut (.mclk(mclk), .rst_n(rst_n),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .scl_i(scl_ln), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda_ln), .sda_o(), .sda_oe(sda_oe), .irq(irq));
  bsu_slave_model i_slave (.scl(scl_ln), .sda(sda_ln), .ack_en(ack_en),
    .slow(slow), .sda_pull(sda_pull), .scl_pull(scl_pull),
    .last_byte(last_byte));
  // ****************************************************
  // Bench tasks
  // ****************************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d,
                        input logic [1:0] er = `BSU_RESP_OKAY);
    int k;
    k = 0;
    awa <= {28'h0, a};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv && k < 100);
    chk({6'h0, bresp}, {6'h0, er});
    if (k == 100) begin err_count++; report_and_stop(); end
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [7:0] d,
                        input logic [1:0] er = `BSU_RESP_OKAY);
    int k;
    k = 0;
    ara <= {28'h0, a};
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
      if (arr) arv <= 1'b0;
    end while (!rv && k < 100);
    d = rd[7:0];
    chk({6'h0, rresp}, {6'h0, er});
    if (k == 100) begin err_count++; report_and_stop(); end
  endtask : axi_rd
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, e);
    logic [7:0] d;
    axi_rd(a, d);
    chk(d & m, e);
  endtask : rd_chk
  task automatic wait_done;
    logic [7:0] d;
    int k;
    k = 0;
    do begin
      axi_rd(`BSU_OFF_CTRL, d);
      k++;
    end while (!d[`BSU_CTRL_DONE] && k < 400);
    if (!d[`BSU_CTRL_DONE]) begin err_count++; report_and_stop(); end
  endtask : wait_done
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    #1000000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd_chk(`BSU_OFF_CTRL, 8'hff, 8'h00);
    rd_chk(`BSU_OFF_STATUS, 8'hff, 8'hf8);
    rd_chk(`BSU_OFF_DATA, 8'hff, 8'h00);
    rd_chk(`BSU_OFF_CPUFLAGS, 8'hff, 8'h00);
    axi_wr(4'h2, 8'h55, `BSU_RESP_SLVERR);
    axi_rd(4'h2, v, `BSU_RESP_SLVERR);
    axi_wr(`BSU_OFF_STATUS, 8'h01);
    rd_chk(`BSU_OFF_STATUS, 8'h07, 8'h01);
    axi_wr(`BSU_OFF_CPUFLAGS, 8'h80);
    for (int i = 0; i < 6; i++) begin
      ack_en <= ack_mask[i];
      slow <= slow_mask[i];
      axi_wr(`BSU_OFF_DATA, step_data[i]);
      axi_wr(`BSU_OFF_CTRL, step_ctrl[i]);
      rd_chk(`BSU_OFF_CTRL, 8'h80, 8'h00);
      chk({7'h0, irq}, 8'h00);
      wait_done();
      chk({7'h0, irq}, {7'h0, step_ctrl[i][0]});
      chk({7'h0, scl_oe}, 8'h01);
      rd_chk(`BSU_OFF_STATUS, 8'hf8,
             {step_code[i], 3'h0});
      if (!step_ctrl[i][5]) chk(last_byte, step_data[i]);
      if (i == 0) begin
        // Flag bit left at zero: nothing may launch
        axi_wr(`BSU_OFF_CTRL, 8'h05);
        rd_chk(`BSU_OFF_CTRL, 8'h80, 8'h80);
        rd_chk(`BSU_OFF_STATUS, 8'hf8, 8'h08);
        axi_wr(`BSU_OFF_CPUFLAGS, 8'h00);
        rd_chk(`BSU_OFF_CPUFLAGS, 8'h80, 8'h00);
        chk({7'h0, irq}, 8'h00);
        axi_wr(`BSU_OFF_CPUFLAGS, 8'h80);
        rd_chk(`BSU_OFF_CPUFLAGS, 8'h80, 8'h80);
        chk({7'h0, irq}, 8'h01);
      end
    end
    axi_wr(`BSU_OFF_CTRL, 8'h94);
    for (n = 0; n < 300 && (scl_oe || sda_oe); n++) @(posedge mclk);
    if (n == 300) err_count++;
    rd_chk(`BSU_OFF_CTRL, 8'h80, 8'h00);
    chk({6'h0, sda_ln, scl_ln}, 8'h03);
    chk({7'h0, irq}, 8'h00);
    report_and_stop();
  end
endmodule : test_two_wire_sw_handshake
`default_nettype wire
